// ===== src/clock_power_mode_control.sv
// Wake-up sequencing, power-mode enables and clock-source/trim control.
// Assumes a synchronous core clock, a register master on Avalon-MM and
// an asynchronous LIN receive line that is synchronised here.
//
// Function
// - after reset release: core reset off, RAM self-test starts, serial port usable
// - after core reset release, microcontroller reset is deasserted
// - scratchpad and FIFO RAM usable only after self-test finishes
// - at power-up only microcontroller and LIN run; analog blocks off
// - active enable resets off; when set powers amplifier, ADC, drivers
// - regulator enable resets off; setting it turns on the burst supply
// - ready flag reports burst capacitor charged to regulation voltage
// - regulator target follows the software voltage select register
// - clock select: 00/11 internal, 01 internal with sync, 10 crystal
// - sync mode measures two falling SYNC edges and adjusts trim
// - measured sync count readable; effective sync lands near 1667
// - override bit lets software write the trim code directly
// - six-bit trim, midpoint 32, about 120 kHz per step
// - sync correction unavailable in buffered SCI mode
// - sync correction holds clock near 16 MHz within half percent
`timescale 1ns/10ps
module clock_power_mode_control
  import cpm_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [3:0] address, // Avalon word address.
  input wire logic read, // Avalon read strobe.
  input wire logic write, // Avalon write strobe.
  input wire logic [31:0] writedata, // Avalon write data.
  output logic [31:0] readdata, // Avalon read data.
  output logic waitrequest, // Avalon wait request.
  input wire logic lin_rx, // Asynchronous LIN receive line.
  input wire logic sci_buffered, // Buffered SCI mode is selected.
  input wire logic supply_at_level, // Analog comparator: capacitor charged.
  output logic core_reset_n, // Digital core reset, active low.
  output logic mcu_reset_n, // Microcontroller reset, active low.
  output logic spi_ready, // Serial peripheral port usable.
  output logic bist_start, // RAM self-test running.
  output logic ram_ready, // Scratchpad and FIFO RAM usable.
  output logic active_enable, // Powers amplifier, ADC and drivers.
  output logic burst_supply_enable, // Burst capacitor regulator on.
  output logic [7:0] burst_supply_voltage_select, // Regulator target.
  output logic [1:0] clk_source, // 0: internal, 1: synced, 2: crystal.
  output logic [5:0] oscillator_trim_code, // Oscillator trim code.
  output logic irq // Level interrupt.
);
  seq_type seq_r;
  sync_type sy_r;
  logic [15:0] bist_cnt_r;
  logic [15:0] charge_cnt_r;
  logic active_r;
  logic supply_en_r;
  logic [7:0] vsel_r;
  logic [1:0] clk_sel_r;
  logic trim_override_bit;
  logic [5:0] sw_trim_r;
  logic [5:0] trim_r;
  logic [15:0] sync_cnt_r;
  logic [15:0] meas_r;
  logic [1:0] edges_r;
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_d_r;
  logic burst_supply_ready_flag;
  logic [EV_COUNT-1:0] irq_stat_r;
  logic [EV_COUNT-1:0] irq_en_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic core_n_r;
  logic mcu_n_r;
  logic ram_ok_r;
  logic irq_r;
  logic bist_r;
  logic wreq_r;
  logic [1:0] clk_src_r;
  logic lvl_s1_r;
  logic lvl_s2_r;

  // Decode, answer one cycle after the request is seen.
  wire req = (read | write) & ~ack_r;
  wire wr_hit = write & ack_r;
  wire wr_pm = wr_hit & (address == OFS_POWER_MODE_REGISTER);
  wire wr_cs = wr_hit & (address == OFS_CLK_SEL);
  wire wr_tc = wr_hit & (address == OFS_TRIM_CTRL);
  wire wr_vs = wr_hit & (address == OFS_VSEL);
  wire wr_ie = wr_hit & (address == OFS_IRQ_ENABLE);
  wire wr_ic = wr_hit & (address == OFS_IRQ_CLEAR);
  wire rx_fall = rx_d_r & ~rx_s2_r;
  // Sync measurement is blocked in buffered SCI mode.
  wire sync_on = (clk_sel_r == CLK_INT_SYNC) & ~sci_buffered;
  wire sync_good = (sync_cnt_r >= SYNC_NOMINAL - SYNC_TOL) &&
                   (sync_cnt_r <= SYNC_NOMINAL + SYNC_TOL);
  wire trim_slow = sync_cnt_r < SYNC_NOMINAL - SYNC_TOL;
  wire trim_fast = sync_cnt_r > SYNC_NOMINAL + SYNC_TOL;
  wire bist_end = (seq_r == SEQ_BIST) &&
                  (bist_cnt_r == 16'(BIST_CYC - 1));
  wire charged = supply_en_r && lvl_s2_r &&
                 (charge_cnt_r == 16'(CHARGE_CYC));
  wire sync_end = (sy_r == SY_COUNT) & rx_fall & (edges_r == 2'h0);
  wire sync_last = (sy_r == SY_COUNT) & rx_fall & (edges_r == 2'h3);
  wire meas_full = meas_r == 16'hFFFF;
  wire supply_off = wr_pm & ~writedata[PM_SUPPLY_BIT];
  wire [1:0] clk_src_nxt = (clk_sel_r == CLK_XTAL) ? CLK_XTAL :
                           (sync_on ? CLK_INT_SYNC : CLK_INT_A);
  wire [EV_COUNT-1:0] ev;
  assign ev[EV_BIST_DONE] = bist_end;
  assign ev[EV_SUPPLY_RDY] = charged & ~burst_supply_ready_flag;
  assign ev[EV_SYNC_DONE] = sync_end;

  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    unique case (address)
      OFS_POWER_MODE_REGISTER: rmux = {30'h0, supply_en_r, active_r};
      OFS_STATUS: rmux = {29'h0, sync_good, ram_ok_r,
                          burst_supply_ready_flag};
      OFS_CLK_SEL: rmux = {30'h0, clk_sel_r};
      OFS_TRIM_CTRL: rmux = {23'h0, trim_override_bit, 2'h0, trim_r};
      OFS_SYNC_COUNT: rmux = {16'h0, sync_cnt_r};
      OFS_VSEL: rmux = {24'h0, vsel_r};
      OFS_IRQ_STATUS: rmux = {29'h0, irq_stat_r};
      OFS_IRQ_ENABLE: rmux = {29'h0, irq_en_r};
      default: rmux = 32'h0;
    endcase
  end

  // Bus handshake: waitrequest drops in the cycle after the request.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      wreq_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= req;
      wreq_r <= ~req;
      rdata_r <= req ? rmux : rdata_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seq_r <= SEQ_RESET;
      bist_cnt_r <= 16'h0;
    end else begin
      unique case (seq_r)
        SEQ_RESET: seq_r <= SEQ_CORE;
        SEQ_CORE: seq_r <= SEQ_BIST;
        SEQ_BIST: begin
          bist_cnt_r <= bist_cnt_r + 16'h1;
          if (bist_end) begin
            seq_r <= SEQ_RUN;
          end
        end
        SEQ_RUN: seq_r <= SEQ_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      core_n_r <= 1'b0;
      mcu_n_r <= 1'b0;
      ram_ok_r <= 1'b0;
      bist_r <= 1'b0;
    end else begin
      core_n_r <= (seq_r != SEQ_RESET);
      bist_r <= (seq_r != SEQ_RESET) & ~(ram_ok_r | bist_end);
      mcu_n_r <= core_n_r;
      ram_ok_r <= ram_ok_r | bist_end;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_r <= 1'b0;
      supply_en_r <= 1'b0;
      vsel_r <= 8'h0;
    end else begin
      if (wr_pm) begin
        active_r <= writedata[PM_ACTIVE_BIT];
        supply_en_r <= writedata[PM_SUPPLY_BIT];
      end
      if (wr_vs) begin
        vsel_r <= writedata[7:0];
      end
    end
  end

  // ready flag after a charge settle.
  always_ff @(posedge mclk) begin
    // Dropping the enable clears the flag at once, never a cycle later.
    if (!rst_n || !supply_en_r || supply_off || wr_vs) begin
      charge_cnt_r <= 16'h0;
      burst_supply_ready_flag <= 1'b0;
    end else begin
      if (charge_cnt_r != 16'(CHARGE_CYC)) begin
        charge_cnt_r <= charge_cnt_r + 16'h1;
      end
      burst_supply_ready_flag <= charged;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clk_sel_r <= CLK_INT_A;
      clk_src_r <= CLK_INT_A;
      trim_override_bit <= 1'b0;
      sw_trim_r <= TRIM_MID;
    end else begin
      clk_src_r <= clk_src_nxt;
      if (wr_cs) begin
        clk_sel_r <= writedata[1:0];
      end
      if (wr_tc) begin
        trim_override_bit <= writedata[TRIM_OVR_BIT];
        sw_trim_r <= writedata[5:0];
      end
    end
  end

  // LIN receive line and charge comparator pass two flip-flops first.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_d_r <= 1'b1;
      lvl_s1_r <= 1'b0;
      lvl_s2_r <= 1'b0;
    end else begin
      lvl_s1_r <= supply_at_level;
      lvl_s2_r <= lvl_s1_r;
      rx_s1_r <= lin_rx;
      rx_s2_r <= rx_s1_r;
      rx_d_r <= rx_s2_r;
    end
  end

  // edge-to-edge measurement.
  // Only the first two-bit interval of a field is kept and the later falls
  // are swallowed, so one field gives one trim step; a full count gives up.
  always_ff @(posedge mclk) begin
    if (!rst_n || !sync_on) begin
      sy_r <= SY_IDLE;
      meas_r <= 16'h0;
      edges_r <= 2'h0;
      sync_cnt_r <= rst_n ? sync_cnt_r : 16'h0;
    end else begin
      unique case (sy_r)
        SY_IDLE: if (rx_fall) begin
          sy_r <= SY_COUNT;
          meas_r <= 16'h1;
          edges_r <= 2'h0;
        end
        SY_COUNT: begin
          meas_r <= meas_r + 16'h1;
          if (rx_fall) begin
            edges_r <= edges_r + 2'h1;
          end
          if (sync_end) begin
            sync_cnt_r <= meas_r;
            sy_r <= SY_DONE;
          end else if (sync_last || meas_full) begin
            sy_r <= SY_IDLE;
          end
        end
        SY_DONE: begin
          meas_r <= meas_r + 16'h1;
          sy_r <= SY_COUNT;
        end
        default: sy_r <= SY_IDLE;
      endcase
    end
  end

  // one trim step per measurement, toward nominal.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trim_r <= TRIM_MID;
    end else if (trim_override_bit) begin
      trim_r <= sw_trim_r;
    end else if (sy_r == SY_DONE && sync_on) begin
      if (trim_slow && trim_r != TRIM_MAX) begin
        trim_r <= trim_r + 6'h1;
      end else if (trim_fast && trim_r != TRIM_MIN) begin
        trim_r <= trim_r - 6'h1;
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
      irq_en_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= ev | (irq_stat_r & ~(wr_ic ? writedata[2:0] : 3'h0));
      if (wr_ie) begin
        irq_en_r <= writedata[2:0];
      end
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  assign readdata = rdata_r;
  assign waitrequest = wreq_r;
  assign core_reset_n = core_n_r;
  assign mcu_reset_n = mcu_n_r;
  assign spi_ready = core_n_r;
  assign bist_start = bist_r;
  assign ram_ready = ram_ok_r;
  assign active_enable = active_r;
  assign burst_supply_enable = supply_en_r;
  assign burst_supply_voltage_select = vsel_r;
  assign clk_source = clk_src_r;
  assign oscillator_trim_code = trim_r;
  assign irq = irq_r;

  mcu_after_core_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mcu_reset_n |-> core_reset_n)
    else $error("mcu reset released early");
  ram_after_bist_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(ram_ready) |-> $past(bist_end))
    else $error("ram ready early");
  core_release_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(core_reset_n) |=> bist_start)
    else $error("bist not started");
  supply_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_pm |=> burst_supply_enable == $past(writedata[PM_SUPPLY_BIT]))
    else $error("supply enable not written");
  ready_needs_en_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    burst_supply_ready_flag |-> supply_en_r)
    else $error("ready without supply enable");
  override_trim_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    trim_override_bit |=> trim_r == $past(sw_trim_r))
    else $error("override trim not applied");
  sci_blocks_sync_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    sci_buffered |=> clk_source != CLK_INT_SYNC)
    else $error("sync in buffered mode");
  trim_step_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !trim_override_bit |=>
    (trim_r - $past(trim_r) inside {6'h0, 6'h1, 6'h3F}))
    else $error("trim moved more than one step");
  quiet_start_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !core_reset_n |-> !active_enable && !burst_supply_enable)
    else $error("analog enabled before core release");
  active_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_pm |=> active_enable == $past(writedata[PM_ACTIVE_BIT]))
    else $error("active enable not written");
  vsel_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_vs |=> burst_supply_voltage_select == $past(writedata[7:0]))
    else $error("voltage select not written");
  xtal_select_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clk_sel_r == CLK_XTAL |=> clk_source == CLK_XTAL)
    else $error("crystal source not selected");
  bist_cover_c: cover property (@(posedge mclk) $rose(ram_ready));
  ready_cover_c: cover property (@(posedge mclk)
    $rose(burst_supply_ready_flag));
  sync_cover_c: cover property (@(posedge mclk) sy_r == SY_DONE);
  irq_cover_c: cover property (@(posedge mclk) irq);
endmodule

// ===== src/cpm_pkg.sv
// Constants for the clock, power-mode and wake-up sequencing block.
// Assumes one 50 MHz clock and a 32-bit Avalon-MM register master.
package cpm_pkg;
  localparam int CLK_MHZ = 50;
  // Register word offsets.
  localparam logic [3:0] OFS_POWER_MODE_REGISTER = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_CLK_SEL = 4'h2;
  localparam logic [3:0] OFS_TRIM_CTRL = 4'h3;
  localparam logic [3:0] OFS_SYNC_COUNT = 4'h4;
  localparam logic [3:0] OFS_VSEL = 4'h5;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h7;
  localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
  // Power-mode register fields.
  localparam int PM_ACTIVE_BIT = 0;
  localparam int PM_SUPPLY_BIT = 1;
  // Trim control fields: override bit and six-bit code.
  localparam int TRIM_OVR_BIT = 8;
  localparam logic [5:0] TRIM_MID = 6'h20;
  localparam logic [5:0] TRIM_MAX = 6'h3F;
  localparam logic [5:0] TRIM_MIN = 6'h00;
  // Nominal sync count and its tolerance.
  localparam logic [15:0] SYNC_NOMINAL = 16'h0683;
  localparam logic [15:0] SYNC_TOL = 16'h0008;
  // Clock source encodings.
  localparam logic [1:0] CLK_INT_A = 2'h0;
  localparam logic [1:0] CLK_INT_SYNC = 2'h1;
  localparam logic [1:0] CLK_XTAL = 2'h2;
  // Self-test length and supply charge time, in microseconds.
  localparam int BIST_US = 20;
  localparam int BIST_CYC = BIST_US * CLK_MHZ;
  localparam int CHARGE_US = 50;
  localparam int CHARGE_CYC = CHARGE_US * CLK_MHZ;
  // Interrupt event bits.
  localparam int EV_BIST_DONE = 0;
  localparam int EV_SUPPLY_RDY = 1;
  localparam int EV_SYNC_DONE = 2;
  localparam int EV_COUNT = 3;
  typedef enum logic [1:0] {
    SEQ_RESET, SEQ_CORE, SEQ_BIST, SEQ_RUN
  } seq_type;
  typedef enum logic [1:0] {
    SY_IDLE, SY_COUNT, SY_DONE
  } sync_type;
endpackage

// ===== tb/lin_sync_master.sv
// Behavioural LIN master that sends a SYNC field on the receive line.
// Assumes the bench calls send_sync just after a rising clock edge.
`timescale 1ns/10ps
module lin_sync_master (
  input wire logic mclk, // Clock used to time the bits.
  output logic lin_rx // Bus level seen by the device, idle high.
);
  initial lin_rx = 1'b1;
  // nominal bit rate
  // Start bit, 0x55 low bit first, then the recessive stop level stays.
  task automatic send_sync(input int bit_cyc);
    logic [9:0] frame;
    frame = {1'b1, 8'h55, 1'b0};
    for (int i = 0; i < 10; i++) begin
      lin_rx <= frame[i];
      repeat (bit_cyc) @(posedge mclk);
    end
  endtask
endmodule

// ===== tb/clock_power_mode_control_tb.sv
// Self-checking bench for the clock, power-mode and wake-up block.
// Assumes the slave answers each request; the watchdog ends any hang.
`timescale 1ns/10ps
module clock_power_mode_control_tb;
  import cpm_pkg::*;
  logic mclk, rst_n, read, write, waitrequest, lin_rx, irq;
  logic sci_buffered, supply_at_level, core_reset_n, mcu_reset_n;
  logic spi_ready, bist_start, ram_ready, active_enable;
  logic burst_supply_enable;
  logic [3:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [7:0] burst_supply_voltage_select;
  logic [1:0] clk_source;
  logic [5:0] oscillator_trim_code;
  int fail_count = 0;
  int checks = 0;
  int seed = 32'hFA90;
  int mdl [16];
  clock_power_mode_control i_dut (.mclk, .rst_n, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .lin_rx, .sci_buffered,
    .supply_at_level, .core_reset_n, .mcu_reset_n, .spi_ready,
    .bist_start, .ram_ready, .active_enable, .burst_supply_enable,
    .burst_supply_voltage_select, .clk_source, .oscillator_trim_code, .irq);
  lin_sync_master i_lin (.mclk, .lin_rx);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic [3:0] a, input logic w,
    input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    rd = readdata;
    if (w && a != OFS_IRQ_CLEAR) mdl[a] = d;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge mclk);
  endtask
  // Reads a register and compares it with the model under a given bit mask.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m);
    bus(a, 1'b0, 32'h0);
    chk(rd & m, mdl[a] & m);
  endtask
  task automatic wait_for(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk(s, 1'b1);
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
  initial begin
    logic [1:0] e;
    rst_n = 1'b0;
    {read, write, sci_buffered, supply_at_level} = 4'h0;
    address = 4'h0;
    writedata = 32'h0;
    repeat (3) @(posedge mclk);
    chk({active_enable, burst_supply_enable, ram_ready}, 32'h0);
    chk(oscillator_trim_code, TRIM_MID);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({core_reset_n, spi_ready, bist_start}, 32'h7);
    chk({mcu_reset_n, ram_ready}, 32'h2);
    wait_for(ram_ready, 1200);
    $display("wake-up sequence done");
    bus(OFS_POWER_MODE_REGISTER, 1'b1, 32'h1);
    chk({active_enable, burst_supply_enable}, 32'h2);
    bus(OFS_POWER_MODE_REGISTER, 1'b1, 32'h3);
    chk(burst_supply_enable, 1'b1);
    rd_chk(OFS_POWER_MODE_REGISTER, 32'h3);
    bus(OFS_VSEL, 1'b1, 32'($random(seed)) & 32'hFF);
    chk(burst_supply_voltage_select, mdl[OFS_VSEL]);
    bus(4'hF, 1'b0, 32'h0);
    chk(rd, 32'h0);
    supply_at_level <= 1'b1;
    repeat (2600) @(posedge mclk);
    bus(OFS_STATUS, 1'b0, 32'h0);
    chk(rd[0], 1'b1);
    chk(irq, 1'b0);
    bus(OFS_IRQ_ENABLE, 1'b1, 32'h2);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    bus(OFS_IRQ_CLEAR, 1'b1, 32'h2);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    $display("power modes done");
    for (int v = 0; v < 8; v++) begin
      sci_buffered <= v[2];
      bus(OFS_CLK_SEL, 1'b1, 32'(v[1:0]));
      e = (v[1:0] == 2'h2) ? 2'h2 : (v == 1) ? 2'h1 : 2'h0;
      @(posedge mclk);
      chk(clk_source, e);
      rd_chk(OFS_CLK_SEL, 32'h3);
    end
    $display("clock select done");
    sci_buffered <= 1'b0;
    bus(OFS_CLK_SEL, 1'b1, 32'h1);
    i_lin.send_sync(834);
    bus(OFS_SYNC_COUNT, 1'b0, 32'h0);
    chk(rd > 1665 && rd < 1671, 1'b1);
    bus(OFS_STATUS, 1'b0, 32'h0);
    chk(rd[2], 1'b1);
    chk(oscillator_trim_code, TRIM_MID);
    i_lin.send_sync(800);
    bus(OFS_SYNC_COUNT, 1'b0, 32'h0);
    chk(rd > 1597 && rd < 1603, 1'b1);
    chk(oscillator_trim_code, TRIM_MID + 6'h1);
    sci_buffered <= 1'b1;
    i_lin.send_sync(834);
    bus(OFS_SYNC_COUNT, 1'b0, 32'h0);
    chk(rd > 1597 && rd < 1603, 1'b1);
    $display("sync correction done");
    bus(OFS_TRIM_CTRL, 1'b1, 32'h13F);
    @(posedge mclk);
    chk(oscillator_trim_code, TRIM_MAX);
    bus(OFS_TRIM_CTRL, 1'b1, 32'h100);
    @(posedge mclk);
    chk(oscillator_trim_code, TRIM_MIN);
    rd_chk(OFS_TRIM_CTRL, 32'h13F);
    $display("trim override done");
    wrap_up();
  end
endmodule
